/* File: core/pwc_pkg.sv */
// ----------------------------------------------------------------
// Shared constants for the pulse counter block
// ----------------------------------------------------------------
package pwc_pkg;

	// Widths
	localparam int PW = 28;                          // Period counter width
	localparam int AW = 12;                          // Converter result width

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;       // Mode, polarity, analog lock
	localparam logic [7:0] OFF_PERIOD = 8'h04;       // Manual period in clocks
	localparam logic [7:0] OFF_DUTY   = 8'h08;       // Manual active time in clocks
	localparam logic [7:0] OFF_PMIN   = 8'h0c;       // Analog period at full scale
	localparam logic [7:0] OFF_PMAX   = 8'h10;       // Analog period at zero input
	localparam logic [7:0] OFF_STATUS = 8'h14;       // Live state bits
	localparam logic [7:0] OFF_ACTPER = 8'h18;       // Period now in use
	localparam logic [7:0] OFF_ACTDTY = 8'h1c;       // Active time now in use
	localparam logic [7:0] OFF_ADC    = 8'h20;       // Last converter results

	// Control field positions
	localparam int CTRL_MODE_LSB = 0;                // Two mode bits
	localparam int CTRL_POL_BIT  = 2;                // 1 = high polarity
	localparam int CTRL_ADIS_BIT = 3;                // 1 = analog modes locked out

	// Converter field positions in the result register
	localparam int ADC_FREQ_LSB = 0;
	localparam int ADC_DUTY_LSB = 16;

	// Reset values
	localparam logic [PW-1:0] RST_PERIOD = 28'h0030d40; // 1 kHz at 200 MHz
	localparam logic [PW-1:0] RST_DUTY   = 28'h0000000; // Output inactive
	localparam logic [PW-1:0] RST_PMIN   = 28'h0001f40; // 25 kHz
	localparam logic [PW-1:0] RST_PMAX   = 28'hbebc200; // 1 Hz
	localparam logic [PW-1:0] PER_ONE    = 28'h0000001; // Shortest legal period
	localparam logic [AW-1:0] ADC_FULL   = 12'hfff;     // Full-scale code

	// Operating modes
	typedef enum logic [1:0]
	{
		MODE_OFF,
		MODE_MAN,
		MODE_ADT,
		MODE_AIN
	} pwc_mode_type;

endpackage : pwc_pkg

/* File: core/pwc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Two-stage synchroniser for one asynchronous level
// ----------------------------------------------------------------
module pwc_sync
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Asynchronous level in, synchronised level out
	input  wire logic async_i,
	output logic      sync_o
);

	logic meta_q;                                    // First stage, read only by second
	logic sync_q;                                    // Second stage

	// Two flops in a row, both cleared by reset
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end
		else
		begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule : pwc_sync
`default_nettype wire

/* File: core/pwc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pwc_top
	import pwc_pkg::*;
(
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// APB slave
	input  wire logic          psel_i,
	input  wire logic          penable_i,
	input  wire logic          pwrite_i,
	input  wire logic [7:0]    paddr_i,
	input  wire logic [31:0]   pwdata_i,
	output logic      [31:0]   prdata_o,
	output logic               pready_o,
	output logic               pslverr_o,
	// Converter results, same clock
	input  wire logic          adc_valid_i,
	input  wire logic [AW-1:0] adc_freq_i,
	input  wire logic [AW-1:0] adc_duty_i,
	// Isolated enable pin, asynchronous
	input  wire logic          en_pin_i,
	// Output transistor gate
	output logic               pwm_gate_o
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	pwc_mode_type  mode_q;                           // Operating mode
	pwc_mode_type  mode_d;                           // Next mode
	logic          pol_q;                            // 1 = high polarity
	logic          adis_q;                           // Analog modes locked out
	logic [PW-1:0] per_q;                            // Manual period
	logic [PW-1:0] duty_q;                           // Manual active time
	logic [PW-1:0] pmin_q;                           // Analog shortest period
	logic [PW-1:0] pmax_q;                           // Analog longest period
	logic [AW-1:0] adc_f_q;                          // Frequency conversion
	logic [AW-1:0] adc_d_q;                          // Duty conversion
	logic [PW-1:0] sh_per_q;                         // Shadow period
	logic [PW-1:0] sh_duty_q;                        // Shadow active time
	logic [PW-1:0] act_per_q;                        // Period in use
	logic [PW-1:0] act_duty_q;                       // Active time in use
	logic [PW-1:0] cnt_q;                            // Period counter
	logic [PW-1:0] cnt_d;                            // Next count
	logic          gate_q;                           // Registered gate
	logic [31:0]   prdata_q;                         // Read data held for access
	logic          pslverr_q;                        // Error held for access
	logic          en_sync;                          // Synchronised enable

	// ----------------------------------------------------------------
	// Enable pin synchroniser
	// ----------------------------------------------------------------
	pwc_sync u_en_sync
	(
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (en_pin_i),
		.sync_o  (en_sync)
	);

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire logic acc_wr   = psel_i & penable_i & pwrite_i;  // Write commits here
	wire logic setup_rd = psel_i & ~penable_i;            // Read data captured here
	wire logic hit_ctrl = (paddr_i == OFF_CTRL);
	wire logic hit_per  = (paddr_i == OFF_PERIOD);
	wire logic hit_duty = (paddr_i == OFF_DUTY);
	wire logic hit_pmin = (paddr_i == OFF_PMIN);
	wire logic hit_pmax = (paddr_i == OFF_PMAX);
	wire logic hit_stat = (paddr_i == OFF_STATUS);
	wire logic hit_aper = (paddr_i == OFF_ACTPER);
	wire logic hit_adty = (paddr_i == OFF_ACTDTY);
	wire logic hit_adc  = (paddr_i == OFF_ADC);
	wire logic hit_any  = hit_ctrl | hit_per | hit_duty | hit_pmin | hit_pmax |
		hit_stat | hit_aper | hit_adty | hit_adc;
	wire logic wr_ctrl  = acc_wr & hit_ctrl;
	wire logic wr_per   = acc_wr & hit_per;
	wire logic wr_duty  = acc_wr & hit_duty;
	wire logic wr_pmin  = acc_wr & hit_pmin;
	wire logic wr_pmax  = acc_wr & hit_pmax;

	// ----------------------------------------------------------------
	// Mode selection with analog lockout
	// ----------------------------------------------------------------
	// Requested mode from the write data
	wire pwc_mode_type req_mode = pwc_mode_type'(pwdata_i[CTRL_MODE_LSB +: 2]);
	wire pwc_mode_type mode_wr  = wr_ctrl ? req_mode : mode_q;
	wire logic adis_new = wr_ctrl ? pwdata_i[CTRL_ADIS_BIT] : adis_q;
	wire logic wr_an    = (mode_wr == MODE_ADT) || (mode_wr == MODE_AIN);
	wire logic cur_an   = (mode_q == MODE_ADT) || (mode_q == MODE_AIN);

	// Locked out: refuse an analog request, drop a running analog mode
	assign mode_d = (adis_new && wr_an) ? (cur_an ? MODE_OFF : mode_q) : mode_wr;

	// Control register: mode, polarity, lockout
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mode_q <= MODE_OFF;
			pol_q  <= 1'b0;
			adis_q <= 1'b0;
		end
		else
		begin
			mode_q <= mode_d;
			if (wr_ctrl)
			begin
				pol_q  <= pwdata_i[CTRL_POL_BIT];
				adis_q <= pwdata_i[CTRL_ADIS_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// Timing registers loaded by software
	// ----------------------------------------------------------------
	// Period, active time and analog limits, counted in clocks
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			per_q  <= RST_PERIOD;
			duty_q <= RST_DUTY;
			pmin_q <= RST_PMIN;
			pmax_q <= RST_PMAX;
		end
		else
		begin
			if (wr_per)
				per_q <= pwdata_i[PW-1:0];
			if (wr_duty)
				duty_q <= pwdata_i[PW-1:0];
			if (wr_pmin)
				pmin_q <= pwdata_i[PW-1:0];
			if (wr_pmax)
				pmax_q <= pwdata_i[PW-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Converter capture
	// ----------------------------------------------------------------
	// Latest 12-bit results, taken on each valid strobe
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			adc_f_q <= '0;
			adc_d_q <= '0;
		end
		else if (adc_valid_i)
		begin
			adc_f_q <= adc_freq_i;
			adc_d_q <= adc_duty_i;
		end
	end

	// ----------------------------------------------------------------
	// Analog scaling
	// ----------------------------------------------------------------
	// Higher frequency input shortens the period from pmax toward pmin
	wire logic [PW-1:0]    span    = pmax_q - pmin_q;
	wire logic [PW+AW-1:0] f_prod  = {{AW{1'b0}}, span} * {{PW{1'b0}}, adc_f_q};
	wire logic [PW-1:0]    f_off   = f_prod[PW+AW-1:AW];
	wire logic [PW-1:0]    adc_per = (adc_f_q == ADC_FULL) ? pmin_q :
		(pmax_q - f_off);

	// Period chosen for the next shadow load
	wire logic [PW-1:0] sel_per = (mode_q == MODE_AIN) ? adc_per : per_q;
	wire logic [PW-1:0] use_per = (sel_per == '0) ? PER_ONE : sel_per;

	// Duty input scales zero to the whole period, full scale means always on
	wire logic [PW+AW-1:0] d_prod   = {{AW{1'b0}}, use_per} * {{PW{1'b0}}, adc_d_q};
	wire logic [PW-1:0]    adc_dty  = (adc_d_q == ADC_FULL) ? use_per :
		d_prod[PW+AW-1:AW];
	wire logic             an_duty  = (mode_q == MODE_ADT) || (mode_q == MODE_AIN);
	wire logic [PW-1:0]    sel_duty = an_duty ? adc_dty : duty_q;

	// ----------------------------------------------------------------
	// Counter control
	// ----------------------------------------------------------------
	// Running needs a live mode and the isolated enable
	wire logic run  = (mode_q != MODE_OFF) && en_sync;
	wire logic wrap = run && (cnt_q >= (act_per_q - PER_ONE));  // Last clock of period
	wire logic load = wrap || !run;
	// Active portion: zero never, period or more always
	wire logic on   = run && (cnt_q < act_duty_q);

	assign cnt_d = load ? '0 : (cnt_q + PER_ONE);

	// ----------------------------------------------------------------
	// Shadow and active timing
	// ----------------------------------------------------------------
	// Shadow follows the selected source every clock
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sh_per_q  <= RST_PERIOD;
			sh_duty_q <= RST_DUTY;
		end
		else
		begin
			sh_per_q  <= use_per;
			sh_duty_q <= sel_duty;
		end
	end

	// Active values change only at a wrap or while stopped
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			act_per_q  <= RST_PERIOD;
			act_duty_q <= RST_DUTY;
		end
		else if (load)
		begin
			act_per_q  <= sh_per_q;
			act_duty_q <= sh_duty_q;
		end
	end

	// Period counter restarts at zero after each wrap
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

	// ----------------------------------------------------------------
	// Output stage
	// ----------------------------------------------------------------
	// Gate high conducts the load to ground; high polarity inverts,
	// so the same wave reads as the complementary duty
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			gate_q <= 1'b0;
		else
			gate_q <= on ^ pol_q;
	end

	assign pwm_gate_o = gate_q;

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	wire logic [31:0] rd_ctrl = {28'h0000000, adis_q, pol_q, mode_q};
	wire logic [31:0] rd_stat = {27'h0000000, mode_q == MODE_OFF, on, run, en_sync, gate_q};
	wire logic [31:0] rd_adc  = {4'h0, adc_d_q, 4'h0, adc_f_q};
	wire logic [31:0] rd_mux  =
		hit_ctrl ? rd_ctrl :
		hit_per  ? {4'h0, per_q} :
		hit_duty ? {4'h0, duty_q} :
		hit_pmin ? {4'h0, pmin_q} :
		hit_pmax ? {4'h0, pmax_q} :
		hit_stat ? rd_stat :
		hit_aper ? {4'h0, act_per_q} :
		hit_adty ? {4'h0, act_duty_q} :
		hit_adc  ? rd_adc : 32'h00000000;

	// Read data and error captured in the setup cycle
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end
		else if (setup_rd)
		begin
			prdata_q  <= pwrite_i ? 32'h00000000 : rd_mux;
			pslverr_q <= ~hit_any;
		end
	end

	// One access cycle, no wait states
	assign pready_o  = psel_i & penable_i;
	assign prdata_o  = prdata_q;
	assign pslverr_o = pslverr_q & psel_i & penable_i;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Timing in use holds steady mid-period
	chk_period_boundary: assert property (@(posedge clk_i) disable iff (rst_i)
		run && !wrap |=> $stable(act_per_q) && $stable(act_duty_q))
		else $error("Active timing changed inside a period");

	// Wrap loads shadow and restarts the count
	chk_shadow_copy: assert property (@(posedge clk_i) disable iff (rst_i)
		wrap |=> (cnt_q == '0) && (act_per_q == $past(sh_per_q)))
		else $error("Wrap did not reload the counters");

	// Stopped output sits at the polarity's inactive level
	chk_off_level: assert property (@(posedge clk_i) disable iff (rst_i)
		!run ##1 !run |-> pwm_gate_o == $past(pol_q))
		else $error("Stopped output not at inactive level");

	// Losing the enable stops the pulse on the next clock
	chk_enable_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(en_sync) |-> !run ##1 (pwm_gate_o == $past(pol_q)))
		else $error("Enable low did not stop the output");

	// Zero active time never drives
	chk_duty_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		run && (act_duty_q == '0) |=> pwm_gate_o == $past(pol_q))
		else $error("Zero duty drove the output");

	// Active time at or past the period always drives
	chk_duty_full: assert property (@(posedge clk_i) disable iff (rst_i)
		run && (act_duty_q >= act_per_q) |=> pwm_gate_o != $past(pol_q))
		else $error("Full duty left the output idle");

	// Lockout keeps analog modes away
	chk_analog_lock: assert property (@(posedge clk_i) disable iff (rst_i)
		adis_q |-> (mode_q == MODE_OFF) || (mode_q == MODE_MAN))
		else $error("Analog mode active while locked out");

	// Conversions are stored as delivered
	chk_adc_capture: assert property (@(posedge clk_i) disable iff (rst_i)
		adc_valid_i |=> (adc_f_q == $past(adc_freq_i)) && (adc_d_q == $past(adc_duty_i)))
		else $error("Conversion result not captured");

	// Duty-only mode keeps the manual period
	chk_manual_period: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode_q == MODE_ADT) && (per_q != '0) |=> sh_per_q == $past(per_q))
		else $error("Duty-only mode altered the period");

	// Polarity flips the drive level for the same active state
	chk_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
		on && pol_q |=> !pwm_gate_o)
		else $error("High polarity did not invert the drive");

endmodule : pwc_top
`default_nettype wire

/* File: test/pwc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Controller model: loads period and duty counts over APB
// ----------------------------------------------------------------
module pwc_host_model
(
	// Clock
	input  wire logic        clk_i,
	// APB answer from the block
	input  wire logic [31:0] prdata_i,
	input  wire logic        pready_i,
	input  wire logic        pslverr_i,
	// APB request to the block
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic [7:0]       paddr_o,
	output logic [31:0]      pwdata_o
);
	// Idle bus at time zero
	initial
	begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h00000000;
	end

	// One transfer; entered right after a rising edge
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err);
		rdata = 32'hxxxxxxxx;
		err = 1'bx;
		// Setup cycle with all qualifiers valid
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= wr;
		paddr_o <= addr;
		pwdata_o <= wdata;
		@(posedge clk_i);
		penable_o <= 1'b1;
		// Access phase held until ready is seen at a rising edge;
		// only the bench watchdog ends a wait that never answers
		@(posedge clk_i);
		while (pready_i !== 1'b1)
			@(posedge clk_i);
		rdata = prdata_i;
		err = pslverr_i;
		// Release; stale address and data are not left on the lines
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		paddr_o <= ~addr;
		pwdata_o <= ~wdata;
		@(posedge clk_i);
	endtask : xfer
endmodule : pwc_host_model
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Self-checking bench for the pulse counter block
// ----------------------------------------------------------------
module tb_top
	import pwc_pkg::*;
();
	logic          clk_i = 1'b0;   // 200 MHz clock
	logic          rst_i = 1'b1;   // Reset, active high
	logic          psel, penable, pwrite, pready, pslverr, gate;
	logic [7:0]    paddr;
	logic [31:0]   pwdata, prdata;
	logic          adc_valid = 1'b0; // Converter strobe
	logic [AW-1:0] adc_freq = 12'h000;
	logic [AW-1:0] adc_duty = 12'h000;
	logic          en_pin = 1'b1;    // Isolated enable
	int            num_errors = 0;
	int            num_checks = 0;

	// Clock
	always #2.5 clk_i = ~clk_i;

	pwc_host_model pwc_host_model_i (.clk_i(clk_i), .prdata_i(prdata), .pready_i(pready),
		.pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
		.paddr_o(paddr), .pwdata_o(pwdata));
	pwc_top pwc_top_i (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .adc_valid_i(adc_valid),
		.adc_freq_i(adc_freq), .adc_duty_i(adc_duty), .en_pin_i(en_pin), .pwm_gate_o(gate));

	// ----------------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		pwc_host_model_i.xfer(1'b1, a, d, r, e);
	endtask : apb_wr

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		pwc_host_model_i.xfer(1'b0, a, 32'h00000000, r, e);
		check(what, r, exp);
	endtask : rdchk

	// Gate sampled mid-cycle, count of high cycles
	task automatic count_hi(input int n, output logic [31:0] c);
		c = 32'h0;
		repeat (n)
		begin
			@(negedge clk_i);
			c = c + gate;
		end
		@(posedge clk_i);
	endtask : count_hi

	// Length of the next whole high pulse
	task automatic pulse_len(output logic [31:0] c);
		int n;
		for (n = 0; n < 1000 && gate !== 1'b0; n++) @(negedge clk_i);
		for (n = 0; n < 1000 && gate !== 1'b1; n++) @(negedge clk_i);
		c = 32'h1;
		for (n = 0; n < 1000; n++)
		begin
			@(negedge clk_i);
			if (gate !== 1'b1) break;
			c++;
		end
		@(posedge clk_i);
	endtask : pulse_len

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] r;
		logic e;
		rdchk("ctrl", OFF_CTRL, 32'h0);
		rdchk("period", OFF_PERIOD, {4'h0, RST_PERIOD});
		rdchk("duty", OFF_DUTY, {4'h0, RST_DUTY});
		rdchk("pmin", OFF_PMIN, {4'h0, RST_PMIN});
		rdchk("pmax", OFF_PMAX, {4'h0, RST_PMAX});
		// Unmapped place is refused
		pwc_host_model_i.xfer(1'b0, 8'h24, 32'h0, r, e);
		check("unmapped data", r, 32'h0);
		check("unmapped err", {31'h0, e}, 32'h1);
	endtask : t_reset

	// Period 4, duty 1, both polarities and the duty limits
	task automatic t_manual();
		logic [31:0] c;
		apb_wr(OFF_PERIOD, 32'h4);
		apb_wr(OFF_DUTY, 32'h1);
		apb_wr(OFF_CTRL, 32'h1);
		count_hi(20, c);
		count_hi(40, c);
		check("man low", c, 32'd10);
		apb_wr(OFF_CTRL, 32'h5);
		count_hi(12, c);
		count_hi(40, c);
		check("man high", c, 32'd30);
		apb_wr(OFF_CTRL, 32'h1);
		apb_wr(OFF_DUTY, 32'h0);
		count_hi(12, c);
		count_hi(40, c);
		check("duty zero", c, 32'd0);
		apb_wr(OFF_DUTY, 32'h4);
		count_hi(12, c);
		count_hi(40, c);
		check("duty full", c, 32'd40);
	endtask : t_manual

	// Enable pin and Off mode park the gate at the inactive level
	task automatic t_enable();
		logic [31:0] c;
		apb_wr(OFF_DUTY, 32'h2);
		en_pin <= 1'b0;
		count_hi(10, c);
		count_hi(20, c);
		check("pin off low", c, 32'd0);
		apb_wr(OFF_CTRL, 32'h5);
		count_hi(6, c);
		count_hi(20, c);
		check("pin off high", c, 32'd20);
		en_pin <= 1'b1;
		apb_wr(OFF_CTRL, 32'h4);
		count_hi(10, c);
		count_hi(20, c);
		check("off high", c, 32'd20);
		apb_wr(OFF_CTRL, 32'h0);
		count_hi(6, c);
		count_hi(20, c);
		check("off low", c, 32'd0);
	endtask : t_enable

	// Duty written mid-period waits for the period boundary
	task automatic t_boundary();
		logic [31:0] c;
		apb_wr(OFF_PERIOD, 32'd100);
		apb_wr(OFF_DUTY, 32'd50);
		apb_wr(OFF_CTRL, 32'h1);
		pulse_len(c);
		check("pulse 50", c, 32'd50);
		pulse_len(c);
		apb_wr(OFF_DUTY, 32'd20);
		rdchk("act duty old", OFF_ACTDTY, 32'd50);
		pulse_len(c);
		check("pulse 20", c, 32'd20);
		rdchk("act duty new", OFF_ACTDTY, 32'd20);
	endtask : t_boundary

	// Analog sources for both values, then duty only
	task automatic t_analog();
		logic [31:0] c;
		apb_wr(OFF_PMIN, 32'd16);
		apb_wr(OFF_PMAX, 32'd64);
		apb_wr(OFF_PERIOD, 32'd40);
		adc_freq <= 12'h000;
		adc_duty <= 12'h800;
		adc_valid <= 1'b1;
		@(posedge clk_i);
		adc_valid <= 1'b0;
		rdchk("adc", OFF_ADC, 32'h08000000);
		apb_wr(OFF_CTRL, 32'h3);
		count_hi(250, c);
		rdchk("ain period", OFF_ACTPER, 32'd64);
		rdchk("ain duty", OFF_ACTDTY, 32'd32);
		pulse_len(c);
		check("ain pulse", c, 32'd32);
		apb_wr(OFF_CTRL, 32'h2);
		count_hi(150, c);
		rdchk("adt period", OFF_ACTPER, 32'd40);
		rdchk("adt duty", OFF_ACTDTY, 32'd20);
		// Full-scale inputs: shortest period and an always-on duty
		adc_freq <= ADC_FULL;
		adc_duty <= ADC_FULL;
		adc_valid <= 1'b1;
		@(posedge clk_i);
		adc_valid <= 1'b0;
		apb_wr(OFF_CTRL, 32'h3);
		count_hi(150, c);
		rdchk("full period", OFF_ACTPER, 32'd16);
		rdchk("full duty", OFF_ACTDTY, 32'd16);
		count_hi(32, c);
		check("full on", c, 32'd32);
	endtask : t_analog

	// Lockout refuses analog modes and stops a running one
	task automatic t_lockout();
		logic [31:0] c;
		apb_wr(OFF_CTRL, 32'h9);
		apb_wr(OFF_CTRL, 32'hb);
		rdchk("lock refuse", OFF_CTRL, 32'h9);
		apb_wr(OFF_CTRL, 32'h3);
		apb_wr(OFF_CTRL, 32'hb);
		rdchk("lock to off", OFF_CTRL, 32'h8);
		count_hi(6, c);
		count_hi(20, c);
		check("lock gate", c, 32'd0);
	endtask : t_lockout

	// ----------------------------------------------------------------
	// Verdict, sequence and watchdog
	// ----------------------------------------------------------------
	task automatic results();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results

	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk_i);
		check("gate in reset", {31'h0, gate}, 32'h0);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_manual();
		t_enable();
		t_boundary();
		t_analog();
		t_lockout();
		results();
	end

	// Hang guard, well beyond the fourteen hundred or so cycles needed
	initial
	begin
		#60000;
		num_errors++;
		$display("BAD watchdog exp done seen hang");
		results();
	end
endmodule : tb_top
`default_nettype wire
